// ### common/csp_pkg.sv
// package: shared constants of the cyclic synchronous position link
package csp_pkg;
    // data widths
    localparam int POS_W  = 32;
    localparam int SUB_W  = 8;
    localparam int MODE_W = 8;
    localparam int CNT_W  = 16;

    // operating mode value that selects cyclic synchronous position
    localparam logic [MODE_W-1:0] MODE_CSP = 8'h08;

    // submode codes: the two cubic choices (-147 and -148)
    localparam logic [SUB_W-1:0] SUB_CUBIC_MASTER_ACC = 8'h6D;
    localparam logic [SUB_W-1:0] SUB_CUBIC_INT_ACC    = 8'h6C;
    // non-cubic submode field positions
    localparam int SUB_LINEAR_BIT = 0;
    localparam int SUB_MVFF_BIT   = 1;
    localparam int SUB_MAFF_BIT   = 2;

    // timing
    localparam int CLK_NS         = 10;
    localparam int CTRL_LOOP_NS   = 50_000;
    localparam int SYNC_PERIOD_NS = 1_000_000;
    localparam int CUBIC_MIN_NS   = 4_000_000;
    localparam int CTRL_LOOP_CYC  = (CTRL_LOOP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC       = (SYNC_PERIOD_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICKS_PER_SYNC = SYNC_PERIOD_NS / CTRL_LOOP_NS;

    // reset values
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
endpackage

// ### common/csp_if.sv
// interface: cyclic process data from the master to the drive
`timescale 1ns/1ps
interface csp_if;
    import csp_pkg::*;
    logic                    sync_pulse;
    logic                    cyclic_run;
    logic [POS_W-1:0]        commanded_position;
    logic [POS_W-1:0]        position_bias_input;
    logic [POS_W-1:0]        speed_offset_input;
    logic [POS_W-1:0]        force_offset_input;
    logic [SUB_W-1:0]        interp_submode;
    logic [MODE_W-1:0]       operating_mode_select;
    logic                    operation_enable;

    modport master (
        output sync_pulse, cyclic_run, commanded_position,
               position_bias_input, speed_offset_input, force_offset_input,
               interp_submode, operating_mode_select, operation_enable
    );
    modport drive (
        input  sync_pulse, cyclic_run, commanded_position,
               position_bias_input, speed_offset_input, force_offset_input,
               interp_submode, operating_mode_select, operation_enable
    );
endinterface

// ### hw/csp_tick_div.sv
// restartable divider that emits a one-cycle enable every DIV cycles
`timescale 1ns/1ps
module csp_tick_div #(
    parameter int DIV = 5000
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // control
    input  wire logic        restart_i,
    // enable pulse
    output logic             tick_o
);
    import csp_pkg::*;

    localparam logic [31:0] LAST = 32'(DIV - 1);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        tick_q;
    logic        tick_d;

    ////////////////////////////////////////////////////////////////////
    // restart wins so the phase lines up with the event that asked
    always_comb begin
        cnt_d  = cnt_q + 32'h0000_0001;
        tick_d = 1'b0;
        if (restart_i) begin
            cnt_d = 32'h0000_0000;
        end else if (cnt_q >= LAST) begin
            cnt_d  = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule

// ### hw/csp_drive.sv
// drive end: latches cyclic setpoints and interpolates them per loop tick
// Contract
// (RQ1) master sends new position every sync period
// (RQ2) cubic needs speed offset every period
// (RQ3) add position bias to commanded position
// (RQ4) speed offset is velocity ff when selected
// (RQ5) force offset is accel ff when selected
// (RQ6) no interpolation applies target at sync
// (RQ7) linear interpolates position over the period
// (RQ8) cubic position, quadratic velocity between periods
// (RQ9) -147 and -148 mean cubic
// (RQ10) sync period longer than loop period
// (RQ11) cubic: sync period over four loop periods
// (RQ12) prefer cubic only above about 4 ms
// (RQ13) mode value 8 selects this operation
// (RQ14) master ordering: config, cyclic, submode, mode, enable
// (RQ15) setpoints only via sync-bound cyclic data
// (RQ16) master sends ff values; drive never checks
// (RQ17) sync latches, restarts counter; ticks advance
`timescale 1ns/1ps
module csp_drive #(
    parameter int LOOP_CYC = csp_pkg::CTRL_LOOP_CYC,
    parameter int TICKS    = csp_pkg::TICKS_PER_SYNC
) (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   sys_rst_i,
    // link from the master
    csp_if.drive                        bus,
    // setpoints toward the motion loop
    output logic [csp_pkg::POS_W-1:0]   position_setpoint_o,
    output logic [csp_pkg::POS_W-1:0]   speed_ff_term_o,
    output logic [csp_pkg::POS_W-1:0]   accel_ff_term_o,
    output logic                        setpoint_strobe_o,
    output logic                        csp_active_o
);
    import csp_pkg::*;

    localparam logic signed [63:0] NS  = 64'(TICKS);
    localparam logic signed [63:0] NS3 = 64'(TICKS) * 64'(TICKS)
                                         * 64'(TICKS);
    localparam logic [CNT_W-1:0]   K_END = CNT_W'(TICKS);

    logic        active;
    logic        loop_tick;
    logic        cubic;
    logic        cubic_q;
    logic        step;
    logic [CNT_W-1:0] k_q;
    logic [CNT_W-1:0] k_d;
    logic signed [63:0] p0_q, p0_d, p1_q, p1_d;
    logic signed [63:0] b_q, b_d, c_q, c_d, d_q, d_d;
    logic [SUB_W-1:0]   sub_q, sub_d;
    logic [POS_W-1:0]   sv_q, sv_d, sa_q, sa_d;
    logic [POS_W-1:0]   pos_q, pos_d, vff_q, vff_d, aff_q, aff_d;
    logic [POS_W-1:0]   vel_q, vel_d;
    logic               strb_q, strb_d;
    logic signed [63:0] tgt, vnew, vold, diff, kk, lin, cpos, cvel;

    ////////////////////////////////////////////////////////////////////
    // mode gate and loop tick; master must keep sync period > loop
    assign active = bus.operation_enable
                  && (bus.operating_mode_select == MODE_CSP); // RQ13
    assign cubic  = (bus.interp_submode == SUB_CUBIC_MASTER_ACC)
                  || (bus.interp_submode == SUB_CUBIC_INT_ACC); // RQ9

    csp_tick_div #(
        .DIV       (LOOP_CYC)
    ) u_loop_div (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .restart_i (bus.sync_pulse), // RQ17
        .tick_o    (loop_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // sync latch: setpoints enter here, except that with no interpolation tgt goes straight to the output at the sync
    always_comb begin
        tgt  = 64'(signed'(bus.commanded_position))
             + 64'(signed'(bus.position_bias_input)); // RQ3
        vnew = 64'(signed'(bus.speed_offset_input));
        vold = 64'(signed'(sv_q));
        diff = tgt - p1_q;
        p0_d = p0_q;
        p1_d = p1_q;
        b_d  = b_q;
        c_d  = c_q;
        d_d  = d_q;
        sv_d = sv_q;
        sa_d = sa_q;
        sub_d = sub_q;
        if (active && bus.sync_pulse) begin // RQ15
            // previous target becomes the start of the new segment
            p0_d  = p1_q; // RQ17
            p1_d  = tgt;
            sv_d  = bus.speed_offset_input;
            sa_d  = bus.force_offset_input;
            sub_d = bus.interp_submode;
            // hermite coefficients, speed in position units per tick
            b_d = vold * NS; // RQ8
            c_d = 64'sd3 * diff - 64'sd2 * vold * NS - vnew * NS;
            d_d = -64'sd2 * diff + vold * NS + vnew * NS;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            p0_q  <= 64'sh0000_0000_0000_0000;
            p1_q  <= 64'sh0000_0000_0000_0000;
            b_q   <= 64'sh0000_0000_0000_0000;
            c_q   <= 64'sh0000_0000_0000_0000;
            d_q   <= 64'sh0000_0000_0000_0000;
            sv_q  <= POS_RST;
            sa_q  <= POS_RST;
            sub_q <= 8'h00;
        end else begin
            p0_q  <= p0_d;
            p1_q  <= p1_d;
            b_q   <= b_d;
            c_q   <= c_d;
            d_q   <= d_d;
            sv_q  <= sv_d;
            sa_q  <= sa_d;
            sub_q <= sub_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // step counter: restarted by sync, stops at the end of the period
    // so a late sync holds the target instead of overshooting it
    always_comb begin
        k_d = k_q;
        if (bus.sync_pulse || !active) begin
            k_d = '0; // RQ17
        end else if (loop_tick && (k_q != K_END)) begin
            k_d = k_q + CNT_W'(1); // RQ17
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            k_q <= '0;
        end else begin
            k_q <= k_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interpolated setpoint and feed-forward selection
    assign cubic_q = (sub_q == SUB_CUBIC_MASTER_ACC)
                   || (sub_q == SUB_CUBIC_INT_ACC);
    assign step    = active && (loop_tick || bus.sync_pulse);

    always_comb begin
        kk   = 64'(k_q);
        lin  = p0_q + ((p1_q - p0_q) * kk) / NS; // RQ7
        cpos = p0_q + (b_q * kk * NS * NS + c_q * kk * kk * NS
                       + d_q * kk * kk * kk) / NS3; // RQ8
        cvel = (b_q * NS * NS + 64'sd2 * c_q * kk * NS
                + 64'sd3 * d_q * kk * kk) / NS3; // RQ8
        pos_d  = pos_q;
        vel_d  = vel_q;
        vff_d  = vff_q;
        aff_d  = aff_q;
        strb_d = 1'b0;
        if (step && !bus.sync_pulse) begin
            strb_d = 1'b1;
            if (cubic_q) begin
                pos_d = cpos[POS_W-1:0];
                vel_d = cvel[POS_W-1:0];
                vff_d = vel_d;
            end else begin
                if (sub_q[SUB_LINEAR_BIT]) begin
                    pos_d = lin[POS_W-1:0];
                end else begin
                    pos_d = p1_q[POS_W-1:0]; // RQ6
                end
                vel_d = pos_d - pos_q;
                // master value is used unchecked when it owns the term
                vff_d = sub_q[SUB_MVFF_BIT] ? sv_q : vel_d; // RQ4 RQ16
            end
            if ((cubic_q && (sub_q == SUB_CUBIC_MASTER_ACC))
                || (!cubic_q && sub_q[SUB_MAFF_BIT])) begin
                aff_d = sa_q; // RQ5 RQ16
            end else begin
                aff_d = vel_d - vel_q;
            end
        end else if (step && !cubic && !bus.interp_submode[SUB_LINEAR_BIT])
        begin
            // no interpolation: new target takes effect at the sync
            pos_d  = tgt[POS_W-1:0]; // RQ6
            strb_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pos_q  <= POS_RST;
            vel_q  <= POS_RST;
            vff_q  <= POS_RST;
            aff_q  <= POS_RST;
            strb_q <= 1'b0;
        end else begin
            pos_q  <= pos_d;
            vel_q  <= vel_d;
            vff_q  <= vff_d;
            aff_q  <= aff_d;
            strb_q <= strb_d;
        end
    end

    assign position_setpoint_o = pos_q;
    assign speed_ff_term_o     = vff_q;
    assign accel_ff_term_o     = aff_q;
    assign setpoint_strobe_o   = strb_q;
    assign csp_active_o        = active;
endmodule

// ### hw/csp_master.sv
// master end: brings the drive up in order and sends setpoints each sync
`timescale 1ns/1ps
module csp_master #(
    parameter int SYNC_CYC_P = csp_pkg::SYNC_CYC,
    parameter int TICKS      = csp_pkg::TICKS_PER_SYNC
) (
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   sys_rst_i,
    // user side
    input  wire logic                   start_i,
    input  wire logic [csp_pkg::SUB_W-1:0] submode_i,
    input  wire logic [csp_pkg::POS_W-1:0] target_i,
    input  wire logic [csp_pkg::POS_W-1:0] bias_i,
    input  wire logic [csp_pkg::POS_W-1:0] speed_i,
    input  wire logic [csp_pkg::POS_W-1:0] force_i,
    output logic                        running_o,
    output logic                        period_ok_o,
    output logic                        cubic_advised_o,
    // link to the drive
    csp_if.master                       bus
);
    import csp_pkg::*;

    typedef enum logic [5:0] {
        ST_CONFIG = 6'b00_0001,
        ST_CYCLIC = 6'b00_0010,
        ST_SUB    = 6'b00_0100,
        ST_MODE   = 6'b00_1000,
        ST_ENABLE = 6'b01_0000,
        ST_RUN    = 6'b10_0000
    } csp_mst_state_type;

    csp_mst_state_type st_q, st_d;
    logic              sync;
    logic [POS_W-1:0]  tp_q, tp_d, bi_q, bi_d, sp_q, sp_d, fo_q, fo_d;
    logic [SUB_W-1:0]  sub_q, sub_d;
    logic              cubic;

    csp_tick_div #(
        .DIV       (SYNC_CYC_P)
    ) u_sync_div (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .restart_i (1'b0),
        .tick_o    (sync)
    );

    ////////////////////////////////////////////////////////////////////
    // bring-up leaves config on start, then walks one step per sync period (RQ14)
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_CONFIG: if (start_i) st_d = ST_CYCLIC;
            ST_CYCLIC: if (sync) st_d = ST_SUB;
            ST_SUB:    if (sync) st_d = ST_MODE;
            ST_MODE:   if (sync) st_d = ST_ENABLE;
            ST_ENABLE: if (sync) st_d = ST_RUN;
            ST_RUN:    st_d = ST_RUN;
            default:   st_d = ST_CONFIG;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // every sync carries fresh target and offsets, ff included (RQ1 RQ2)
    always_comb begin
        tp_d  = tp_q;
        bi_d  = bi_q;
        sp_d  = sp_q;
        fo_d  = fo_q;
        sub_d = sub_q;
        if (sync) begin
            tp_d = target_i; // RQ1
            bi_d = bias_i;
            sp_d = speed_i; // RQ2 RQ16
            fo_d = force_i; // RQ16
        end
        if (st_q == ST_SUB) begin
            sub_d = submode_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q  <= ST_CONFIG;
            tp_q  <= POS_RST;
            bi_q  <= POS_RST;
            sp_q  <= POS_RST;
            fo_q  <= POS_RST;
            sub_q <= 8'h00;
        end else begin
            st_q  <= st_d;
            tp_q  <= tp_d;
            bi_q  <= bi_d;
            sp_q  <= sp_d;
            fo_q  <= fo_d;
            sub_q <= sub_d;
        end
    end

    // static period checks: ticks per sync against the loop rate, sync period against 4 ms (RQ10 RQ11 RQ12)
    assign cubic = (sub_q == SUB_CUBIC_MASTER_ACC)
                || (sub_q == SUB_CUBIC_INT_ACC);
    assign period_ok_o     = cubic ? (TICKS > 4) : (TICKS > 1);
    assign cubic_advised_o = (SYNC_PERIOD_NS > CUBIC_MIN_NS);

    assign bus.sync_pulse            = sync && (st_q != ST_CONFIG);
    assign bus.cyclic_run            = (st_q != ST_CONFIG);
    assign bus.commanded_position    = tp_q;
    assign bus.position_bias_input   = bi_q;
    assign bus.speed_offset_input    = sp_q;
    assign bus.force_offset_input    = fo_q;
    assign bus.interp_submode        = sub_q;
    assign bus.operating_mode_select = ((st_q == ST_ENABLE)
                                     || (st_q == ST_RUN)) ? MODE_CSP
                                     : 8'h00; // RQ13
    assign bus.operation_enable      = (st_q == ST_RUN);
    assign running_o                 = (st_q == ST_RUN);
endmodule

// ### testbench/csp_link_sva.sv
// checker: timing and order of the cyclic link between master and drive
`timescale 1ns/1ps
module csp_link_sva #(
    parameter int SYNC_CYC_P = csp_pkg::SYNC_CYC
) (
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       sys_rst_i,
    // link signals
    input  wire logic                       sync_pulse,
    input  wire logic                       cyclic_run,
    input  wire logic [csp_pkg::POS_W-1:0]  commanded_position,
    input  wire logic [csp_pkg::POS_W-1:0]  position_bias_input,
    input  wire logic [csp_pkg::POS_W-1:0]  speed_offset_input,
    input  wire logic [csp_pkg::POS_W-1:0]  force_offset_input,
    input  wire logic [csp_pkg::SUB_W-1:0]  interp_submode,
    input  wire logic [csp_pkg::MODE_W-1:0] operating_mode_select,
    input  wire logic                       operation_enable
);
    import csp_pkg::*;
    // wide enough for the full-length default sync period
    logic [31:0] gap_q, gap_d;
    logic        seen_q, seen_d;

    ////////////////////////////////////////////////////////////////////////
    // cycles since the last sync; saturates so a stall cannot wrap to ok
    always_comb begin
        gap_d  = sync_pulse ? 32'h0000_0000 : gap_q + 32'(~&gap_q);
        seen_d = seen_q | (sync_pulse & cyclic_run);
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap_q  <= 32'h0000_0000;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= gap_d;
            seen_q <= seen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // target and offsets may only move right after a sync event
    sequence s_just_synced;
        $past(sync_pulse);
    endsequence
    sequence s_mode_set;
        operating_mode_select == MODE_CSP;
    endsequence

    sync_spacing_a: assert property (sync_pulse && seen_q && cyclic_run
        |-> gap_q == SYNC_CYC_P - 1) else $error("sync spacing wrong");
    sync_gap_a: assert property (cyclic_run && seen_q
        |-> gap_q < SYNC_CYC_P) else $error("sync period missed");
    mode_value_a: assert property (operating_mode_select != '0
        |-> s_mode_set) else $error("mode value not csp");
    mode_after_cyclic_a: assert property (s_mode_set |-> cyclic_run)
        else $error("mode set before cyclic data");
    enable_order_a: assert property ($rose(operation_enable)
        |-> $past(operating_mode_select) == MODE_CSP && cyclic_run)
        else $error("enable before mode");
    enable_mode_a: assert property (operation_enable |-> s_mode_set)
        else $error("enable without mode");
    submode_hold_a: assert property (s_mode_set ##1 s_mode_set
        |-> $stable(interp_submode)) else $error("submode moved late");
    target_at_sync_a: assert property ($changed(commanded_position)
        |-> s_just_synced) else $error("target moved off sync");
    offset_at_sync_a: assert property ($changed(speed_offset_input)
        || $changed(position_bias_input) || $changed(force_offset_input)
        |-> s_just_synced) else $error("offset moved off sync");
endmodule

// ### testbench/cyclic_sync_position_interp_tb.sv
// testbench: master and drive joined by the link, checked per submode
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    failures++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module cyclic_sync_position_interp_tb;
    import csp_pkg::*;
    // small counts keep the run short: 10 loop ticks per sync
    localparam int LOOP = 4;
    localparam int SCYC = 40;
    localparam int NT   = 10;
    typedef struct {
        logic [POS_W-1:0] pos;
        logic [POS_W-1:0] spd;
        logic [POS_W-1:0] acc;
        bit               ff;
    } csp_note_type;
    logic             sys_clk_i, sys_rst_i, start_i;
    logic [SUB_W-1:0] submode_i;
    logic [POS_W-1:0] target_i, bias_i, speed_i, force_i;
    logic             running_o, period_ok_o, cubic_advised_o;
    logic [POS_W-1:0] pos_o, spd_o, acc_o;
    logic             strobe_o, active_o;
    int               failures, tests_run, cycles;
    csp_note_type     notes[$];
    csp_note_type     n;
    logic [SUB_W-1:0] subs[7] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h05,
                                  SUB_CUBIC_MASTER_ACC, SUB_CUBIC_INT_ACC};
    csp_if link ();

    ////////////////////////////////////////////////////////////////////////
    csp_master #(.SYNC_CYC_P(SCYC), .TICKS(NT)) csp_master_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
        .submode_i(submode_i), .target_i(target_i), .bias_i(bias_i),
        .speed_i(speed_i), .force_i(force_i), .running_o(running_o),
        .period_ok_o(period_ok_o), .cubic_advised_o(cubic_advised_o),
        .bus(link.master));
    csp_drive #(.LOOP_CYC(LOOP), .TICKS(NT)) csp_drive_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus(link.drive),
        .position_setpoint_o(pos_o), .speed_ff_term_o(spd_o),
        .accel_ff_term_o(acc_o), .setpoint_strobe_o(strobe_o),
        .csp_active_o(active_o));
    csp_link_sva #(.SYNC_CYC_P(SCYC)) csp_link_sva_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .sync_pulse(link.sync_pulse), .cyclic_run(link.cyclic_run),
        .commanded_position(link.commanded_position),
        .position_bias_input(link.position_bias_input),
        .speed_offset_input(link.speed_offset_input),
        .force_offset_input(link.force_offset_input),
        .interp_submode(link.interp_submode),
        .operating_mode_select(link.operating_mode_select),
        .operation_enable(link.operation_enable));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic tally_and_finish();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watcher: strobe marks settled outputs, so sample mid-cycle
    // own note variable, so the stimulus side never sees it overwritten
    always @(negedge sys_clk_i) begin
        csp_note_type m;
        cycles++;
        if (cycles == 8000) begin
            failures++;
            tally_and_finish();
        end
        if (strobe_o === 1'b1 && notes.size() > 0) begin
            m = notes.pop_front();
            `CHK("setpoint", m.pos, pos_o)
            if (m.ff) begin
                `CHK("speed_ff", m.spd, spd_o)
                `CHK("accel_ff", m.acc, acc_o)
            end
        end
    end

    task automatic wait_empty();
        for (int i = 0; i < 4 * SCYC && notes.size() > 0; i++) begin
            @(posedge sys_clk_i);
        end
        `CHK("notes_left", 0, notes.size())
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one submode: bring-up, settled check, then a step in the target for non-cubic submodes
    task automatic run_sub(input logic [SUB_W-1:0] sub);
        logic [POS_W-1:0] a, b, bs, sp, fo;
        bit               cub;
        cub = sub == SUB_CUBIC_MASTER_ACC || sub == SUB_CUBIC_INT_ACC;
        a   = $urandom_range(1000000);
        b   = a + $urandom_range(5000, 100);
        bs  = $urandom_range(1000);
        sp  = cub ? '0 : POS_W'($urandom_range(500, 1));
        fo  = $urandom_range(500, 1);
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        start_i   <= 1'b0;
        submode_i <= sub;
        target_i  <= a;
        bias_i    <= bs;
        speed_i   <= sp;
        force_i   <= fo;
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("active_idle", 1'b0, active_o)
        @(posedge sys_clk_i);
        start_i <= 1'b1;
        // look at settled outputs, away from the edge that moves them
        for (int i = 0; i < 8 * SCYC && running_o !== 1'b1; i++) begin
            @(negedge sys_clk_i);
        end
        repeat (3 * SCYC) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK("active", 1'b1, active_o)
        `CHK("period_ok", 1'b1, period_ok_o)
        `CHK("cubic_advised", 1'b0, cubic_advised_o)
        n.pos = a + bs;
        n.spd = (!cub && sub[SUB_MVFF_BIT]) ? sp : '0;
        n.acc = (cub ? sub == SUB_CUBIC_MASTER_ACC : sub[SUB_MAFF_BIT])
                ? fo : '0;
        n.ff  = 1'b1;
        notes.push_back(n);
        notes.push_back(n);
        wait_empty();
        if (!cub) begin
            target_i <= b;
            for (int i = 0; i < 3 * SCYC; i++) begin
                @(negedge sys_clk_i);
                if (link.sync_pulse === 1'b1
                    && link.commanded_position === b) break;
            end
            n.ff = 1'b0;
            // last tick of a period may meet the next sync, so stop short
            for (int k = 0; k < (sub[SUB_LINEAR_BIT] ? NT - 1 : 1); k++)
            begin
                n.pos = sub[SUB_LINEAR_BIT]
                    ? a + bs + (b - a) * POS_W'(k) / POS_W'(NT)
                    : b + bs;
                notes.push_back(n);
            end
            wait_empty();
        end
    endtask

    initial begin
        sys_rst_i = 1'b1;
        start_i   = 1'b0;
        submode_i = '0;
        target_i  = '0;
        bias_i    = '0;
        speed_i   = '0;
        force_i   = '0;
        failures  = 0;
        tests_run = 0;
        cycles    = 0;
        void'($urandom(52113));
        foreach (subs[i]) begin
            run_sub(subs[i]);
        end
        tally_and_finish();
    end
endmodule
